// ### hw/atp_top.sv
// acquisition control, pacer, trigger, sample FIFO and host port
`timescale 1ns/10ps
module atp_top #(
  parameter logic [9:0] IO_BASE   = 10'h300,
  parameter int         FIFO_DEPTH = 2048,
  parameter int         CHAN_W    = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host I/O and memory pins
  input  wire logic [9:0]  host_addr,
  input  wire logic        host_iow_n,
  input  wire logic        host_ior_n,
  input  wire logic [15:0] host_data_in,
  output logic [15:0]      host_data_out,
  output logic             host_data_oe,
  input  wire logic        host_mem_req_n,
  output logic             host_mem_ready,
  output logic [3:0]       host_irq_out,
  output logic [3:0]       host_irq_oe,
  output logic [15:0]      sm_base,
  output logic [15:0]      sm_page,
  // local processor side
  input  wire logic        dsp_strb,
  input  wire logic        dsp_wr,
  input  wire logic [2:0]  dsp_addr,
  input  wire logic [31:0] dsp_wdata,
  output logic [31:0]      dsp_rdata,
  output logic             dsp_rdy,
  output logic             dsp_hold_n,
  input  wire logic        dsp_holda_n,
  input  wire logic        dsp_host_irq,
  output logic [3:0]       dsp_int,
  input  wire logic        ext_int,
  // acquisition pins
  input  wire logic        xtal_clk,
  input  wire logic        ext_timebase,
  input  wire logic        ext_sample_clk_n,
  input  wire logic        ext_trig,
  input  wire logic        comp_trip,
  output logic [11:0]      trig_level,
  output logic             adc_start,
  input  wire logic        adc_eoc,
  input  wire logic [15:0] adc_data,
  output logic [CHAN_W-1:0] adc_chan
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = 12 + 10 + 16 + 16;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [11:0]   prev_reg;

  assign raw = {xtal_clk, ext_timebase, ext_sample_clk_n, ext_trig,
                comp_trip, adc_eoc, ext_int, dsp_host_irq, host_iow_n,
                host_ior_n, host_mem_req_n, dsp_holda_n,
                host_addr, host_data_in, adc_data};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg[SW-1 -: 12];
    end
  end

  logic [11:0] sl;
  logic [9:0]  h_addr;
  logic [15:0] h_din;
  logic [15:0] a_data;
  logic [11:0] rise;
  logic [11:0] fall;
  assign sl     = s2_reg[SW-1 -: 12];
  assign h_addr = s2_reg[41:32];
  assign h_din  = s2_reg[31:16];
  assign a_data = s2_reg[15:0];
  assign rise   = sl & ~prev_reg;
  assign fall   = ~sl & prev_reg;

  // ----------------------------------------------------------------------
  // host I/O registers
  // ----------------------------------------------------------------------
  logic [15:0] cmd_reg;
  logic [15:0] status;
  logic        h_sel;
  logic        h_wr;
  logic        h_rd_active;

  // window decoded on A9..A3, A2..A0 pick the register
  assign h_sel       = (h_addr[9:3] == IO_BASE[9:3]);
  assign h_wr        = fall[3] && h_sel;
  assign h_rd_active = !sl[2] && h_sel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= atp_pkg::CMD_RST;
      sm_base <= '0;
      sm_page <= '0;
    end else if (h_wr) begin
      case (h_addr[2:0])
        atp_pkg::HOST_CMD_OFS:  cmd_reg <= h_din;
        atp_pkg::HOST_BASE_OFS: sm_base <= h_din;
        atp_pkg::HOST_PAGE_OFS: sm_page <= h_din;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= h_rd_active &&
                      (h_addr[2:0] == atp_pkg::HOST_STAT_OFS);
      if (fall[2] && h_sel) begin
        host_data_out <= status;
      end
    end
  end

  // ----------------------------------------------------------------------
  // host interrupt and shared memory hold
  // ----------------------------------------------------------------------
  logic [3:0] irq_line;
  always_comb begin
    irq_line = 4'h0;
    irq_line[cmd_reg[atp_pkg::CMD_IRQ_SEL_LSB +: 2]] =
      cmd_reg[atp_pkg::CMD_IRQ_EN];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_irq_out   <= '0;
      host_irq_oe    <= '0;
      dsp_hold_n     <= 1'b1;
      host_mem_ready <= 1'b1;
    end else begin
      host_irq_oe  <= irq_line;
      host_irq_out <= irq_line & {4{sl[4]}};
      // dynamic hold lasts one host access; ready waits for the ack
      dsp_hold_n <= !(cmd_reg[atp_pkg::CMD_HOLD] ||
                      (cmd_reg[atp_pkg::CMD_DYN_HOLD] && !sl[1]));
      host_mem_ready <= sl[1] || !sl[0];
    end
  end

  // ----------------------------------------------------------------------
  // local registers with wait states
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] div_reg;
  logic [15:0] count_reg;
  logic [15:0] wait_reg;
  logic [2:0]  wcnt_reg;
  logic        served_reg;
  logic        take;
  logic        loc_wr;
  logic        fifo_pop;
  logic [31:0] fifo_rdata;
  logic        start_cmd;
  logic        abort_cmd;

  assign take      = dsp_strb && !served_reg &&
                     (wcnt_reg == wait_reg[atp_pkg::WT_LSB +: 3]);
  assign loc_wr    = take && dsp_wr;
  assign fifo_pop  = take && !dsp_wr && (dsp_addr == atp_pkg::LOC_FIFO);
  assign start_cmd = loc_wr && (dsp_addr == atp_pkg::LOC_CTRL) &&
                     dsp_wdata[atp_pkg::CTL_START];
  assign abort_cmd = loc_wr && (dsp_addr == atp_pkg::LOC_CTRL) &&
                     dsp_wdata[atp_pkg::CTL_ABORT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_reg   <= '0;
      served_reg <= 1'b0;
      dsp_rdy    <= 1'b0;
    end else begin
      dsp_rdy <= take;
      if (!dsp_strb) begin
        wcnt_reg   <= '0;
        served_reg <= 1'b0;
      end else if (take) begin
        served_reg <= 1'b1;
      end else if (!served_reg) begin
        wcnt_reg <= wcnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= atp_pkg::CTRL_RST;
      div_reg    <= atp_pkg::DIV_RST;
      count_reg  <= atp_pkg::COUNT_RST;
      wait_reg   <= atp_pkg::WAIT_RST;
      trig_level <= atp_pkg::LEVEL_RST[11:0];
    end else if (loc_wr) begin
      case (dsp_addr)
        atp_pkg::LOC_CTRL:  ctrl_reg  <= dsp_wdata[15:0];
        atp_pkg::LOC_DIV:   div_reg   <= dsp_wdata[15:0];
        atp_pkg::LOC_COUNT: count_reg <= (dsp_wdata[15:0] < atp_pkg::SAMPLE_MIN)
                                         ? atp_pkg::SAMPLE_MIN
                                         : dsp_wdata[15:0];
        atp_pkg::LOC_WAIT:  wait_reg  <= dsp_wdata[15:0];
        atp_pkg::LOC_LEVEL: trig_level <= dsp_wdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_rdata <= '0;
    end else if (take && !dsp_wr) begin
      case (dsp_addr)
        atp_pkg::LOC_CTRL:  dsp_rdata <= {16'h0000, ctrl_reg};
        atp_pkg::LOC_DIV:   dsp_rdata <= {16'h0000, div_reg};
        atp_pkg::LOC_COUNT: dsp_rdata <= {16'h0000, count_reg};
        atp_pkg::LOC_WAIT:  dsp_rdata <= {16'h0000, wait_reg};
        atp_pkg::LOC_STAT:  dsp_rdata <= {16'h0000, status};
        atp_pkg::LOC_LEVEL: dsp_rdata <= {20'h00000, trig_level};
        default:            dsp_rdata <= '0;
      endcase
    end else if (dsp_rdy && (dsp_addr == atp_pkg::LOC_FIFO)) begin
      // popped word lands one cycle after the pop
      dsp_rdata <= fifo_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // pacer and conversion start
  // ----------------------------------------------------------------------
  atp_pkg::atp_state_t state_reg;
  logic converting;
  logic tb_tick;
  logic pace_pulse;
  logic trig_evt;

  assign converting = (state_reg == atp_pkg::ATP_PRE) ||
                      (state_reg == atp_pkg::ATP_RUN);
  assign tb_tick = ctrl_reg[atp_pkg::CTL_TB_EXT] ? rise[10] : rise[11];

  atp_pacer #(.DIV_W(16)) u_pacer (
    .clk         (clk),
    .rst_n       (rst_n),
    .run         (converting),
    .tick        (tb_tick),
    .divisor     (div_reg),
    .start_pulse (pace_pulse)
  );

  // external sample clock is active low; start on its falling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= converting &&
                   (ctrl_reg[atp_pkg::CTL_CLK_EXT] ? fall[9] : pace_pulse);
    end
  end

  always_comb begin
    case (ctrl_reg[atp_pkg::CTL_TRIG_LSB +: 2])
      atp_pkg::TRIG_EXT:    trig_evt = rise[8];
      atp_pkg::TRIG_ANALOG: trig_evt = rise[7];
      default:              trig_evt = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // acquisition sequence and sample counter
  // ----------------------------------------------------------------------
  logic [15:0] left_reg;
  logic        eoc;
  assign eoc = rise[6] && converting;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= atp_pkg::ATP_IDLE;
      left_reg  <= '0;
    end else if (abort_cmd) begin
      state_reg <= atp_pkg::ATP_IDLE;
    end else begin
      case (state_reg)
        atp_pkg::ATP_IDLE, atp_pkg::ATP_DONE: begin
          if (start_cmd) begin
            left_reg  <= count_reg;
            state_reg <= dsp_wdata[atp_pkg::CTL_PRE] ? atp_pkg::ATP_PRE
                                                     : atp_pkg::ATP_ARMED;
          end
        end
        atp_pkg::ATP_ARMED: begin
          if (trig_evt) begin
            state_reg <= atp_pkg::ATP_RUN;
          end
        end
        atp_pkg::ATP_PRE: begin
          if (trig_evt && !(ctrl_reg[atp_pkg::CTL_TRIG_LSB +: 2] ==
                            atp_pkg::TRIG_SW)) begin
            state_reg <= atp_pkg::ATP_RUN;
          end
        end
        atp_pkg::ATP_RUN: begin
          if (eoc) begin
            left_reg <= left_reg - 1'b1;
            if (left_reg == 16'h0001) begin
              state_reg <= atp_pkg::ATP_DONE;
            end
          end
        end
        default: state_reg <= atp_pkg::ATP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // channel order, packing and sample FIFO
  // ----------------------------------------------------------------------
  logic [15:0] low_reg;
  logic        half_reg;
  logic        f_wr;
  logic [31:0] f_wdata;
  logic        f_full;
  logic        f_empty;
  logic        ovf_reg;
  logic        w32;
  logic        ring;
  assign w32  = ctrl_reg[atp_pkg::CTL_W32];
  assign ring = (state_reg == atp_pkg::ATP_PRE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_chan <= '0;
      low_reg  <= '0;
      half_reg <= 1'b0;
      f_wr     <= 1'b0;
      f_wdata  <= '0;
    end else begin
      f_wr <= 1'b0;
      if (start_cmd) begin
        adc_chan <= '0;
        half_reg <= 1'b0;
      end else if (eoc) begin
        adc_chan <= (adc_chan == ctrl_reg[atp_pkg::CTL_CHAN_LSB +: CHAN_W])
                    ? '0 : adc_chan + 1'b1;
        if (w32 && !half_reg) begin
          low_reg  <= a_data;
          half_reg <= 1'b1;
        end else begin
          half_reg <= 1'b0;
          f_wr     <= 1'b1;
          f_wdata  <= w32 ? {a_data, low_reg} : {16'h0000, a_data};
        end
      end
    end
  end

  // refused writes past full in normal mode mark an overrun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_reg <= 1'b0;
    end else if (f_wr && f_full && !ring) begin
      ovf_reg <= 1'b1;
    end else if (start_cmd) begin
      ovf_reg <= 1'b0;
    end
  end

  atp_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (start_cmd),
    .ring  (ring),
    .wr    (f_wr),
    .wdata (f_wdata),
    .rd    (fifo_pop),
    .rdata (fifo_rdata),
    .full  (f_full),
    .empty (f_empty)
  );

  // ----------------------------------------------------------------------
  // status and local interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    status = 16'h0000;
    status[atp_pkg::ST_FULL]    = f_full;
    status[atp_pkg::ST_DONE]    = (state_reg == atp_pkg::ATP_DONE);
    status[atp_pkg::ST_DSP_IRQ] = sl[4];
    status[atp_pkg::ST_HOLDA]   = !sl[0];
    status[atp_pkg::ST_EMPTY]   = f_empty;
    status[atp_pkg::ST_OVF]     = ovf_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsp_int <= '0;
    end else begin
      dsp_int <= {sl[5] && wait_reg[atp_pkg::WT_EXT_EN],
                  state_reg == atp_pkg::ATP_DONE,
                  !f_empty,
                  cmd_reg[atp_pkg::CMD_DSP_REQ]};
    end
  end
endmodule

// ### hw/atp_pkg.sv
// constants, field layout and types of the acquisition and host port block
// ----------------------------------------------------------------------
// What this block does
// - converter start rate is the timebase divided by a 16-bit pacer divisor
// - pacer timebase selects the 10 MHz crystal or an external TTL clock
// - sample counter counts conversions, programmed count from 3 to 65,535
// - in pretrigger mode the down counter holds until the trigger arrives
// - pretrigger samples go to a ring buffer, oldest overwritten
// - analog trigger is a comparator with threshold from an onboard DAC
// - scan trigger and sample clock may both come from external inputs
// - three 16-bit host I/O registers, decoded on address lines 9 to 3
// - host moves bulk data by 16-bit memory block transfers
// - one host interrupt line, software picks level 9, 10, 11 or 15
// - host interrupt rises only on a local processor request
// - host access holds local processor by control bit or per access
// - shared memory 128k x 32, up to 2048k x 32, both sides reach it
// - local bus cycles stretched by 0 to 7 programmed wait states
// - four local interrupts from host request, FIFO, acquisition, external
// - sample FIFO of 2048 or 8192 samples, output 16 or 32 bits wide
// - multichannel samples leave in ascending channel order, wrapping to 0
// - at full rate samples stop being stored once the FIFO is full
// ----------------------------------------------------------------------
package atp_pkg;
  // ----------------------------------------------------------------------
  // host I/O offsets (byte offsets from the I/O base)
  // ----------------------------------------------------------------------
  localparam logic [2:0] HOST_CMD_OFS   = 3'h0;
  localparam logic [2:0] HOST_STAT_OFS  = 3'h0;
  localparam logic [2:0] HOST_BASE_OFS  = 3'h2;
  localparam logic [2:0] HOST_PAGE_OFS  = 3'h4;
  // host command fields
  localparam int CMD_IRQ_SEL_LSB = 0;
  localparam int CMD_IRQ_EN      = 2;
  localparam int CMD_HOLD        = 3;
  localparam int CMD_DYN_HOLD    = 4;
  localparam int CMD_DSP_REQ     = 5;
  // status fields (host and local)
  localparam int ST_FULL    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_DSP_IRQ = 2;
  localparam int ST_HOLDA   = 3;
  localparam int ST_EMPTY   = 4;
  localparam int ST_OVF     = 5;
  // ----------------------------------------------------------------------
  // local register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] LOC_CTRL  = 3'h0;
  localparam logic [2:0] LOC_DIV   = 3'h1;
  localparam logic [2:0] LOC_COUNT = 3'h2;
  localparam logic [2:0] LOC_WAIT  = 3'h3;
  localparam logic [2:0] LOC_FIFO  = 3'h4;
  localparam logic [2:0] LOC_STAT  = 3'h5;
  localparam logic [2:0] LOC_LEVEL = 3'h6;
  // control fields
  localparam int CTL_START    = 0;
  localparam int CTL_TB_EXT   = 1;
  localparam int CTL_CLK_EXT  = 2;
  localparam int CTL_TRIG_LSB = 3;
  localparam int CTL_PRE      = 5;
  localparam int CTL_W32      = 6;
  localparam int CTL_ABORT    = 7;
  localparam int CTL_CHAN_LSB = 8;
  // wait register fields
  localparam int WT_LSB    = 0;
  localparam int WT_EXT_EN = 3;
  // ----------------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [15:0] CMD_RST    = 16'h0000;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] DIV_RST    = 16'h000A;
  localparam logic [15:0] COUNT_RST  = 16'h0003;
  localparam logic [15:0] WAIT_RST   = 16'h0007;
  localparam logic [15:0] LEVEL_RST  = 16'h0800;
  localparam logic [15:0] SAMPLE_MIN = 16'h0003;
  // trigger sources
  localparam logic [1:0] TRIG_SW     = 2'h0;
  localparam logic [1:0] TRIG_EXT    = 2'h1;
  localparam logic [1:0] TRIG_ANALOG = 2'h2;

  typedef enum logic [4:0] {
    ATP_IDLE  = 5'b00001,
    ATP_ARMED = 5'b00010,
    ATP_PRE   = 5'b00100,
    ATP_RUN   = 5'b01000,
    ATP_DONE  = 5'b10000
  } atp_state_t;
endpackage

// ### hw/atp_pacer.sv
// pacer divider: one start pulse every divisor timebase ticks
`timescale 1ns/10ps
module atp_pacer #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  start_pulse
);
  logic [DIV_W-1:0] cnt_reg;

  // divisor 0 behaves as full 2^16 count, as a timer wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg     <= '0;
      start_pulse <= 1'b0;
    end else if (!run) begin
      cnt_reg     <= divisor - 1'b1;
      start_pulse <= 1'b0;
    end else if (tick) begin
      start_pulse <= (cnt_reg == '0);
      cnt_reg     <= (cnt_reg == '0) ? divisor - 1'b1 : cnt_reg - 1'b1;
    end else begin
      start_pulse <= 1'b0;
    end
  end
endmodule

// ### hw/atp_fifo.sv
// sample FIFO with an optional ring mode that overwrites the oldest entry
`timescale 1ns/10ps
module atp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 2048
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         ring,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         rd,
  output logic [W-1:0]      rdata,
  output logic              full,
  output logic              empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0]   cnt_reg;
  logic          do_wr;
  logic          do_rd;
  logic          drop;

  assign full  = (cnt_reg == (AW+1)'(DEPTH));
  assign empty = (cnt_reg == '0);
  // full and not ring: sample is refused
  assign do_wr = wr && (!full || ring);
  assign drop  = do_wr && full;
  assign do_rd = rd && !empty && !drop;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr_reg] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
      rdata    <= '0;
    end else if (clear) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (do_rd || drop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      if (do_rd) begin
        rdata <= mem[rptr_reg];
      end
      if (do_wr && !drop && !do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ### sim/atp_properties.sv
// checker of the acquisition and host port block
`timescale 1ns/10ps
module atp_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       host_ior_n,
  input wire logic       host_data_oe,
  input wire logic       host_mem_req_n,
  input wire logic       host_mem_ready,
  input wire logic [3:0] host_irq_out,
  input wire logic [3:0] host_irq_oe,
  input wire logic       dsp_strb,
  input wire logic       dsp_rdy,
  input wire logic       dsp_holda_n,
  input wire logic       dsp_host_irq,
  input wire logic       adc_start
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request synchroniser needs a few cycles before ready may react
  sequence s_req_held;
    !host_mem_req_n [*4];
  endsequence
  AST_RDY_ONE: assert property (dsp_rdy |=> !dsp_rdy)
    else $error("ready longer than one cycle");
  AST_RDY_BOUND: assert property ($rose(dsp_strb) |-> ##[1:8] dsp_rdy)
    else $error("local access not answered within seven waits");
  AST_RDY_CAUSE: assert property (dsp_rdy |-> $past(dsp_strb))
    else $error("ready without strobe");
  AST_IRQ_SRC: assert property (|host_irq_out |-> $past(dsp_host_irq, 3))
    else $error("host interrupt without local request");
  AST_IRQ_ONE: assert property ($onehot0(host_irq_oe))
    else $error("more than one host interrupt line driven");
  AST_START_ONE: assert property (adc_start |=> !adc_start)
    else $error("converter start longer than one cycle");
  AST_OE_READ: assert property (host_data_oe |->
      !($past(host_ior_n, 3) && $past(host_ior_n, 4)))
    else $error("data driven without read strobe");
  AST_MEM_HOLD: assert property (s_req_held |->
      !host_mem_ready || !$past(dsp_holda_n, 2))
    else $error("memory ready without hold acknowledge");
endmodule
bind atp_top atp_properties u_chk (.clk, .rst_n, .host_ior_n,
  .host_data_oe, .host_mem_req_n, .host_mem_ready, .host_irq_out,
  .host_irq_oe, .dsp_strb, .dsp_rdy, .dsp_holda_n, .dsp_host_irq,
  .adc_start);

// ### sim/atp_far_model.sv
// far side model: local processor hold answer and converter
`timescale 1ns/10ps
module atp_far_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       dsp_hold_n,
  output logic            dsp_holda_n,
  input  wire logic       adc_start,
  input  wire logic [3:0] adc_chan,
  output logic            adc_eoc,
  output logic [15:0]     adc_data
);
  // ----------------------------------------------------------------
  // hold answer and converter
  // ----------------------------------------------------------------
  logic [1:0] dly_reg;
  logic [3:0] chan_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dsp_holda_n <= 1'b1;
    else dsp_holda_n <= dsp_hold_n;
  end
  // data toggles outside eoc so stale samples never look valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg <= 2'h0;
      chan_reg <= 4'h0;
      adc_eoc <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      dly_reg <= adc_start ? 2'h2 : dly_reg - {1'b0, |dly_reg};
      if (adc_start) chan_reg <= adc_chan;
      adc_eoc <= (dly_reg == 2'h1);
      adc_data <= (dly_reg == 2'h1) ? {12'h0A5, chan_reg} : ~adc_data;
    end
  end
endmodule

// ### sim/tb.sv
// self-checking bench of the acquisition and host port block
`timescale 1ns/10ps
module tb;
  logic        clk, rst_n, host_iow_n, host_ior_n, host_mem_req_n;
  logic        host_data_oe, host_mem_ready, dsp_strb, dsp_wr, dsp_rdy;
  logic        dsp_hold_n, dsp_holda_n, dsp_host_irq, xtal_clk;
  logic        adc_start, adc_eoc, ext_trig;
  logic [2:0]  dsp_addr;
  logic [3:0]  host_irq_out, host_irq_oe, dsp_int, adc_chan;
  logic [9:0]  host_addr;
  logic [11:0] trig_level;
  logic [15:0] host_data_in, host_data_out, sm_base, sm_page, adc_data;
  logic [31:0] dsp_wdata, dsp_rdata, r;
  int          fail_count = 0;
  int          compares = 0;
  int          n;
  atp_top DUT (.clk, .rst_n, .host_addr, .host_iow_n, .host_ior_n,
    .host_data_in, .host_data_out, .host_data_oe, .host_mem_req_n,
    .host_mem_ready, .host_irq_out, .host_irq_oe, .sm_base, .sm_page,
    .dsp_strb, .dsp_wr, .dsp_addr, .dsp_wdata, .dsp_rdata, .dsp_rdy,
    .dsp_hold_n, .dsp_holda_n, .dsp_host_irq, .dsp_int, .ext_int(1'b0),
    .xtal_clk, .ext_timebase(1'b0), .ext_sample_clk_n(1'b1),
    .ext_trig, .comp_trip(1'b0), .trig_level, .adc_start,
    .adc_eoc, .adc_data, .adc_chan);
  atp_far_model u_far (.clk, .rst_n, .dsp_hold_n, .dsp_holda_n,
    .adc_start, .adc_chan, .adc_eoc, .adc_data);
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // a used-up wait bound is a mismatch and ends the run
  task automatic tmo(input int k);
    if (n >= k) begin
      fail_count++;
      conclude;
    end
  endtask
  task automatic wdone;
    for (n = 0; n < 900 && dsp_int[2] !== 1'b1; n++) cyc(1);
    tmo(900);
  endtask
  // strobes held five cycles, above the four the port needs
  task automatic hwr(input logic [2:0] o, input logic [15:0] d);
    host_addr <= 10'h300 | {7'h00, o};
    host_data_in <= d;
    host_iow_n <= 1'b0;
    cyc(5);
    host_iow_n <= 1'b1;
    cyc(5);
  endtask
  task automatic hrd(output logic [15:0] d);
    host_addr <= 10'h300;
    host_ior_n <= 1'b0;
    cyc(6);
    chk(host_data_oe, 1);
    d = host_data_out;
    host_ior_n <= 1'b1;
    cyc(6);
  endtask
  task automatic lacc(input logic w, input logic [2:0] a,
                      input logic [31:0] v);
    dsp_strb <= 1'b1;
    dsp_wr <= w;
    dsp_addr <= a;
    dsp_wdata <= v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dsp_rdy !== 1'b1 && n < 30);
    dsp_strb <= 1'b0;
    @(posedge clk);
    r = dsp_rdata;
    tmo(30);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    xtal_clk = 1'b0;
    forever #50 xtal_clk = ~xtal_clk;
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {host_iow_n, host_ior_n, host_mem_req_n} = 3'h7;
    {dsp_strb, dsp_wr, dsp_host_irq, ext_trig, dsp_addr} = 7'h00;
    {host_addr, host_data_in, dsp_wdata} = '0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(3);
    chk(trig_level, 12'h800);
    hrd(r[15:0]);
    chk(r[15:0] & 16'h0013, 16'h0010);
    hwr(3'h2, 16'hA5C3);
    hwr(3'h4, 16'h0F1E);
    hwr(3'h6, 16'hFFFF);
    chk(sm_base, 16'hA5C3);
    chk(sm_page, 16'h0F1E);
    lacc(1'b0, 3'h3, 0);
    chk(n, 9);
    lacc(1'b1, 3'h3, 0);
    lacc(1'b0, 3'h3, 0);
    chk(n, 2);
    lacc(1'b1, 3'h2, 2);
    lacc(1'b0, 3'h2, 0);
    chk(r[15:0], 16'h0003);
    lacc(1'b1, 3'h6, 32'h0123);
    chk(trig_level, 12'h123);
    dsp_host_irq <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      hwr(3'h0, 16'h0004 | 16'(i));
      chk(host_irq_oe, 4'h1 << i);
      chk(host_irq_out[i], 1);
    end
    hwr(3'h0, 16'h0020);
    chk(host_irq_oe, 0);
    chk(dsp_int[0], 1);
    dsp_host_irq <= 1'b0;
    hwr(3'h0, 16'h0008);
    chk(dsp_hold_n, 0);
    hwr(3'h0, 16'h0010);
    host_mem_req_n <= 1'b0;
    cyc(4);
    for (n = 0; n < 30 && host_mem_ready !== 1'b1; n++) cyc(1);
    tmo(30);
    chk(dsp_hold_n, 0);
    host_mem_req_n <= 1'b1;
    // pacer far below the external clock limit
    lacc(1'b1, 3'h1, 1);
    lacc(1'b1, 3'h2, 3);
    lacc(1'b1, 3'h0, 32'h0101);
    wdone;
    hrd(r[15:0]);
    chk(r[1], 1);
    for (int k = 0; k < 3; k++) begin
      lacc(1'b0, 3'h4, 0);
      chk(r[15:0], {12'h0A5, 4'(k % 2)});
    end
    hrd(r[15:0]);
    chk(r[4], 1);
    // pretrigger, external trigger: count must hold until the trigger
    lacc(1'b1, 3'h0, 32'h0129);
    cyc(100);
    chk(dsp_int[2], 0);
    ext_trig <= 1'b1;
    wdone;
    conclude;
  end
endmodule
